// *** rtl/cbo_bridge.sv ***
// Core bus interface: ordering policy, master-abort reporting, registers
`timescale 1ns/1ps
module cbo_bridge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic core_req_valid,
    output logic core_req_ready,
    input wire logic core_req_write,
    input wire logic [31:0] core_req_addr,
    input wire logic [31:0] core_req_wdata,
    input wire logic [2:0] core_req_policy,
    input wire logic core_req_mcu,
    output logic core_rsp_valid,
    output logic [31:0] core_rsp_rdata,
    output logic core_rsp_error,
    output logic ib_cmd_valid,
    input wire logic ib_cmd_ready,
    output logic ib_cmd_write,
    output logic [31:0] ib_cmd_addr,
    output logic [31:0] ib_cmd_wdata,
    output logic ib_cmd_fill,
    input wire logic ib_cpl_valid,
    input wire logic ib_cpl_write,
    input wire logic ib_cpl_mabort,
    input wire logic [31:0] ib_cpl_rdata,
    output logic mcu_cmd_valid,
    input wire logic mcu_cmd_ready,
    output logic mcu_cmd_write,
    output logic [31:0] mcu_cmd_addr,
    output logic [31:0] mcu_cmd_wdata,
    input wire logic mcu_cpl_valid,
    input wire logic [31:0] mcu_cpl_rdata
);
    typedef struct packed {
        cbo_pkg::cbo_core_state_e state;
        logic rd_out;
        logic wr_out;
        logic rsp_valid;
        logic [31:0] rsp_rdata;
        logic rsp_error;
    } cbo_core_s;

    cbo_core_s core_reg;
    cbo_core_s core_next;

    logic data_cache_en;
    logic abort_evt;
    logic ib_load;
    logic mcu_load;
    logic ld_fill;
    logic accept;
    logic [2:0] state_bits;
    cbo_pkg::cbo_class_e req_cls;

    // Region policy to ordering class
    function automatic cbo_pkg::cbo_class_e classify(input logic [2:0] pol, input logic dc_en);
        if (pol == cbo_pkg::POL_STALL)
        begin
            classify = cbo_pkg::CLS_STALL;
        end
        else if (pol[cbo_pkg::POL_C_BIT] && pol[cbo_pkg::POL_B_BIT] && dc_en)
        begin
            classify = cbo_pkg::CLS_CACHE;
        end
        else
        begin
            // Write-through, bufferable, and cacheable with cache off
            classify = cbo_pkg::CLS_BUF;
        end
    endfunction

    assign req_cls = classify(core_req_policy, data_cache_en);

    always_comb
    begin
        core_req_ready = 1'b0;
        if (core_reg.state == cbo_pkg::CS_IDLE)
        begin
            if (core_req_mcu || req_cls == cbo_pkg::CLS_STALL)
            begin
                // Waits behind everything already issued
                core_req_ready = !core_reg.rd_out && !core_reg.wr_out
                    && !ib_cmd_valid && !mcu_cmd_valid;
            end
            else if (core_req_write)
            begin
                // Posted write may go while a read is still pending
                core_req_ready = !core_reg.wr_out && !ib_cmd_valid;
            end
            else
            begin
                core_req_ready = !core_reg.rd_out && !ib_cmd_valid;
            end
        end
    end

    assign accept = core_req_valid && core_req_ready;
    assign ib_load = accept && !core_req_mcu;
    assign mcu_load = accept && core_req_mcu;
    assign ld_fill = !core_req_write && req_cls == cbo_pkg::CLS_CACHE;

    // Both aborts report through the same source bit
    assign abort_evt = ib_cpl_valid && ib_cpl_mabort
        && (ib_cpl_write ? core_reg.wr_out : core_reg.rd_out);

    always_comb
    begin
        core_next = core_reg;
        core_next.rsp_valid = 1'b0;
        if (accept)
        begin
            if (core_req_mcu)
            begin
                // One access at a time keeps issue order
                core_next.state = cbo_pkg::CS_WAIT_MCU;
            end
            else if (core_req_write)
            begin
                core_next.wr_out = 1'b1;
                if (req_cls == cbo_pkg::CLS_STALL)
                begin
                    core_next.state = cbo_pkg::CS_WAIT_WR;
                end
            end
            else
            begin
                core_next.rd_out = 1'b1;
                if (req_cls != cbo_pkg::CLS_BUF)
                begin
                    // Line fill and load finish before any later write
                    core_next.state = cbo_pkg::CS_WAIT_RD;
                end
            end
        end
        if (ib_cpl_valid && ib_cpl_write && core_reg.wr_out)
        begin
            core_next.wr_out = 1'b0;
            if (core_reg.state == cbo_pkg::CS_WAIT_WR)
            begin
                core_next.state = cbo_pkg::CS_IDLE;
                core_next.rsp_valid = 1'b1;
                core_next.rsp_rdata = '0;
                core_next.rsp_error = 1'b0;
            end
        end
        if (ib_cpl_valid && !ib_cpl_write && core_reg.rd_out)
        begin
            core_next.rd_out = 1'b0;
            core_next.rsp_valid = 1'b1;
            core_next.rsp_rdata = ib_cpl_rdata;
            // Direct error regardless of the mask
            core_next.rsp_error = ib_cpl_mabort;
            if (core_reg.state == cbo_pkg::CS_WAIT_RD)
            begin
                core_next.state = cbo_pkg::CS_IDLE;
            end
        end
        if (mcu_cpl_valid && core_reg.state == cbo_pkg::CS_WAIT_MCU)
        begin
            core_next.state = cbo_pkg::CS_IDLE;
            core_next.rsp_valid = 1'b1;
            core_next.rsp_rdata = mcu_cpl_rdata;
            core_next.rsp_error = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_reg.state <= cbo_pkg::CS_IDLE;
            core_reg.rd_out <= 1'b0;
            core_reg.wr_out <= 1'b0;
            core_reg.rsp_valid <= 1'b0;
            core_reg.rsp_rdata <= '0;
            core_reg.rsp_error <= 1'b0;
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    assign core_rsp_valid = core_reg.rsp_valid;
    assign core_rsp_rdata = core_reg.rsp_rdata;
    assign core_rsp_error = core_reg.rsp_error;

    always_comb
    begin
        state_bits = '0;
        state_bits[cbo_pkg::STATE_RD_OUT_BIT] = core_reg.rd_out;
        state_bits[cbo_pkg::STATE_WR_OUT_BIT] = core_reg.wr_out;
        state_bits[cbo_pkg::STATE_BUSY_BIT] = core_reg.state != cbo_pkg::CS_IDLE;
    end

    cbo_cmd_slot u_ib_slot (
        .pclk(pclk),
        .presetn(presetn),
        .load(ib_load),
        .ld_write(core_req_write),
        .ld_addr(core_req_addr),
        .ld_wdata(core_req_wdata),
        .ld_fill(ld_fill),
        .cmd_valid(ib_cmd_valid),
        .cmd_ready(ib_cmd_ready),
        .cmd_write(ib_cmd_write),
        .cmd_addr(ib_cmd_addr),
        .cmd_wdata(ib_cmd_wdata),
        .cmd_fill(ib_cmd_fill)
    );

    cbo_cmd_slot u_mcu_slot (
        .pclk(pclk),
        .presetn(presetn),
        .load(mcu_load),
        .ld_write(core_req_write),
        .ld_addr(core_req_addr),
        .ld_wdata(core_req_wdata),
        .ld_fill(1'b0),
        .cmd_valid(mcu_cmd_valid),
        .cmd_ready(mcu_cmd_ready),
        .cmd_write(mcu_cmd_write),
        .cmd_addr(mcu_cmd_addr),
        .cmd_wdata(mcu_cmd_wdata),
        .cmd_fill()
    );

    cbo_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .abort_evt(abort_evt),
        .state_bits(state_bits),
        .data_cache_en(data_cache_en),
        .irq(irq)
    );
endmodule

// *** rtl/cbo_pkg.sv ***
// Constants and types for the core bus ordering and abort block
package cbo_pkg;
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h004;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h008;
    localparam logic [11:0] STATE_OFFSET = 12'h00C;
    localparam int ABORT_BIT = 29;
    localparam int CTRL_DATA_CACHE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] CTRL_WMASK = 32'h00000001;
    localparam logic [31:0] IRQ_STATUS_RESET = 32'h00000000;
    localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
    localparam logic [31:0] IRQ_MASK_WMASK = 32'h20000000;
    localparam int STATE_RD_OUT_BIT = 0;
    localparam int STATE_WR_OUT_BIT = 1;
    localparam int STATE_BUSY_BIT = 2;
    localparam int POL_X_BIT = 2;
    localparam int POL_C_BIT = 1;
    localparam int POL_B_BIT = 0;
    localparam logic [2:0] POL_STALL = 3'h0;
    typedef enum logic [1:0] {
        CLS_STALL = 2'b00,
        CLS_BUF = 2'b01,
        CLS_CACHE = 2'b10
    } cbo_class_e;
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_WAIT_RD = 2'b01,
        CS_WAIT_WR = 2'b10,
        CS_WAIT_MCU = 2'b11
    } cbo_core_state_e;
endpackage

// *** rtl/cbo_cmd_slot.sv ***
// One-entry command holding slot for an outgoing request channel
`timescale 1ns/1ps
module cbo_cmd_slot (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic ld_write,
    input wire logic [31:0] ld_addr,
    input wire logic [31:0] ld_wdata,
    input wire logic ld_fill,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic cmd_write,
    output logic [31:0] cmd_addr,
    output logic [31:0] cmd_wdata,
    output logic cmd_fill
);
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic fill;
    } cbo_slot_s;

    cbo_slot_s slot_reg;
    cbo_slot_s slot_next;

    always_comb
    begin
        slot_next = slot_reg;
        if (slot_reg.valid && cmd_ready)
        begin
            slot_next.valid = 1'b0;
        end
        // Caller loads only an empty slot
        if (load)
        begin
            slot_next.valid = 1'b1;
            slot_next.write = ld_write;
            slot_next.addr = ld_addr;
            slot_next.wdata = ld_wdata;
            slot_next.fill = ld_fill;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_reg <= '0;
        end
        else
        begin
            slot_reg <= slot_next;
        end
    end

    assign cmd_valid = slot_reg.valid;
    assign cmd_write = slot_reg.write;
    assign cmd_addr = slot_reg.addr;
    assign cmd_wdata = slot_reg.wdata;
    assign cmd_fill = slot_reg.fill;
endmodule

// *** rtl/cbo_apb_regs.sv ***
// APB register file with abort status, mask and interrupt output
`timescale 1ns/1ps
module cbo_apb_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic abort_evt,
    input wire logic [2:0] state_bits,
    output logic data_cache_en,
    output logic irq
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] status;
        logic [31:0] mask;
        logic [31:0] rdata;
        logic err;
    } cbo_apb_s;

    cbo_apb_s regs_reg;
    cbo_apb_s regs_next;

    always_comb
    begin
        logic [31:0] set_bits;
        logic [31:0] clr_bits;
        set_bits = '0;
        clr_bits = '0;
        regs_next = regs_reg;
        // Read data captured at setup so prdata comes from a flop
        if (psel && !penable)
        begin
            regs_next.err = 1'b0;
            case (paddr)
                cbo_pkg::CTRL_OFFSET: regs_next.rdata = regs_reg.ctrl;
                cbo_pkg::IRQ_STATUS_OFFSET: regs_next.rdata = regs_reg.status;
                cbo_pkg::IRQ_MASK_OFFSET: regs_next.rdata = regs_reg.mask;
                cbo_pkg::STATE_OFFSET: regs_next.rdata = {29'h0, state_bits};
                default:
                begin
                    regs_next.rdata = '0;
                    regs_next.err = 1'b1;
                end
            endcase
        end
        // Source bit only latches while enabled in the mask
        set_bits[cbo_pkg::ABORT_BIT] = abort_evt && regs_reg.mask[cbo_pkg::ABORT_BIT];
        // Clear only what the read returned, so a later event survives
        if (psel && penable && !pwrite && paddr == cbo_pkg::IRQ_STATUS_OFFSET)
        begin
            clr_bits = regs_reg.rdata;
        end
        regs_next.status = (regs_reg.status & ~clr_bits) | set_bits;
        if (psel && penable && pwrite)
        begin
            case (paddr)
                cbo_pkg::CTRL_OFFSET: regs_next.ctrl = pwdata & cbo_pkg::CTRL_WMASK;
                cbo_pkg::IRQ_MASK_OFFSET: regs_next.mask = pwdata & cbo_pkg::IRQ_MASK_WMASK;
                default: regs_next.ctrl = regs_reg.ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            regs_reg.ctrl <= cbo_pkg::CTRL_RESET;
            regs_reg.status <= cbo_pkg::IRQ_STATUS_RESET;
            regs_reg.mask <= cbo_pkg::IRQ_MASK_RESET;
            regs_reg.rdata <= '0;
            regs_reg.err <= 1'b0;
        end
        else
        begin
            regs_reg <= regs_next;
        end
    end

    assign prdata = regs_reg.rdata;
    assign pready = 1'b1;
    assign pslverr = regs_reg.err && psel && penable;
    assign data_cache_en = regs_reg.ctrl[cbo_pkg::CTRL_DATA_CACHE_BIT];
    assign irq = |(regs_reg.status & regs_reg.mask);
endmodule

// *** tb/cbo_bridge_assertions.sv ***
// Checker for the core bus ordering and abort block
`timescale 1ns/1ps
module cbo_bridge_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic irq,
    input wire logic core_req_valid,
    input wire logic core_req_ready,
    input wire logic core_req_write,
    input wire logic [2:0] core_req_policy,
    input wire logic core_req_mcu,
    input wire logic core_rsp_valid,
    input wire logic [31:0] core_rsp_rdata,
    input wire logic core_rsp_error,
    input wire logic ib_cmd_valid,
    input wire logic ib_cmd_write,
    input wire logic ib_cpl_valid,
    input wire logic ib_cpl_write,
    input wire logic ib_cpl_mabort,
    input wire logic [31:0] ib_cpl_rdata,
    input wire logic mcu_cmd_valid,
    input wire logic mcu_cpl_valid
);
    logic acc;
    logic mcu_out;
    assign acc = core_req_valid && core_req_ready;
    // Memory-port access in flight, acceptance to completion
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            mcu_out <= 1'b0;
        else if (mcu_cpl_valid)
            mcu_out <= 1'b0;
        else if (acc && core_req_mcu)
            mcu_out <= 1'b1;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_wr_cpl_quiet:
        assert property (ib_cpl_valid && ib_cpl_write |=> !(core_rsp_valid && core_rsp_error))
        else $error("write completion erred core");
    a_rd_abort_err:
        assert property (ib_cpl_valid && !ib_cpl_write && ib_cpl_mabort |=> core_rsp_valid && core_rsp_error)
        else $error("read abort not erred");
    a_rd_data_pass:
        assert property (ib_cpl_valid && !ib_cpl_write && !ib_cpl_mabort
            |=> core_rsp_valid && !core_rsp_error && core_rsp_rdata == $past(ib_cpl_rdata))
        else $error("read data lost");
    a_irq_held:
        assert property (irq && !psel |=> irq)
        else $error("irq dropped alone");
    a_mcu_strict:
        assert property (mcu_out && !mcu_cpl_valid |-> !core_req_ready && !ib_cmd_valid)
        else $error("memory port overtaken");
    a_mcu_route:
        assert property (acc && core_req_mcu |=> mcu_cmd_valid && !ib_cmd_valid)
        else $error("memory port not used");
    a_stall_hold:
        assert property (acc && core_req_policy == 3'h0 |=> (!core_req_ready) [*2])
        else $error("stall access not waited");
    a_posted_issue:
        assert property (acc && core_req_write && !core_req_mcu && core_req_policy != 3'h0
            |=> ib_cmd_valid && ib_cmd_write)
        else $error("posted write not issued");
endmodule

bind cbo_bridge cbo_bridge_checker i_chk (.*);

// *** tb/cbo_target_model.sv ***
// Internal bus and memory-port target model
`timescale 1ns/1ps
module cbo_target_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] rd_lat,
    input wire logic abort_on,
    input wire logic ib_cmd_valid,
    output logic ib_cmd_ready,
    input wire logic ib_cmd_write,
    input wire logic [31:0] ib_cmd_addr,
    input wire logic [31:0] ib_cmd_wdata,
    output logic ib_cpl_valid,
    output logic ib_cpl_write,
    output logic ib_cpl_mabort,
    output logic [31:0] ib_cpl_rdata,
    input wire logic mcu_cmd_valid,
    output logic mcu_cmd_ready,
    input wire logic mcu_cmd_write,
    input wire logic [31:0] mcu_cmd_addr,
    input wire logic [31:0] mcu_cmd_wdata,
    output logic mcu_cpl_valid,
    output logic [31:0] mcu_cpl_rdata
);
    logic [31:0] mem [16];
    logic [3:0] rc, mc, ra, ma;
    logic rp, wp, mp;
    // Separate read and write slots: a write may finish before a slow read
    assign ib_cmd_ready = ib_cmd_write ? !wp : !rp;
    assign mcu_cmd_ready = !mp;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {rp, wp, mp, rc, mc, ib_cpl_valid, ib_cpl_write, ib_cpl_mabort} <= '0;
            {ib_cpl_rdata, mcu_cpl_valid, mcu_cpl_rdata} <= '0;
            for (int i = 0; i < 16; i++)
                mem[i] <= 32'h0;
        end
        else
        begin
            // Idle data lines toggle so stale values are never trusted
            {ib_cpl_valid, mcu_cpl_valid} <= 2'b00;
            {ib_cpl_rdata, mcu_cpl_rdata} <= ~{ib_cpl_rdata, mcu_cpl_rdata};
            rc <= (rc != 4'h0) ? rc - 4'h1 : rc;
            mc <= (mc != 4'h0) ? mc - 4'h1 : mc;
            if (wp)
                {wp, ib_cpl_valid, ib_cpl_write, ib_cpl_mabort} <= {3'b011, abort_on};
            else if (rp && rc == 4'h0)
            begin
                {rp, ib_cpl_valid, ib_cpl_write, ib_cpl_mabort} <= {3'b010, abort_on};
                ib_cpl_rdata <= mem[ra];
            end
            if (mp && mc == 4'h0)
            begin
                {mp, mcu_cpl_valid} <= 2'b01;
                mcu_cpl_rdata <= mem[ma];
            end
            if (ib_cmd_valid && ib_cmd_ready && ib_cmd_write)
            begin
                wp <= 1'b1;
                if (!abort_on)
                    mem[ib_cmd_addr[5:2]] <= ib_cmd_wdata;
            end
            if (ib_cmd_valid && ib_cmd_ready && !ib_cmd_write)
                {rp, rc, ra} <= {1'b1, rd_lat, ib_cmd_addr[5:2]};
            if (mcu_cmd_valid && mcu_cmd_ready)
            begin
                {mp, mc, ma} <= {1'b1, rd_lat, mcu_cmd_addr[5:2]};
                if (mcu_cmd_write)
                    mem[mcu_cmd_addr[5:2]] <= mcu_cmd_wdata;
            end
        end
    end
endmodule

// *** tb/cbo_bridge_tb_top.sv ***
// Self-checking bench for the core bus ordering and abort block
`timescale 1ns/1ps
module cbo_bridge_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, abort_on, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, core_req_addr, core_req_wdata, core_rsp_rdata, rd, cur;
    logic [31:0] ib_cmd_addr, ib_cmd_wdata, ib_cpl_rdata, mcu_cmd_addr, mcu_cmd_wdata;
    logic [31:0] mcu_cpl_rdata;
    logic core_req_valid, core_req_ready, core_req_write, core_req_mcu, core_rsp_valid;
    logic core_rsp_error, ib_cmd_valid, ib_cmd_ready, ib_cmd_write, ib_cmd_fill, ib_cpl_valid;
    logic ib_cpl_write, ib_cpl_mabort, mcu_cmd_valid, mcu_cmd_ready, mcu_cmd_write, mcu_cpl_valid;
    logic [2:0] core_req_policy;
    logic [3:0] rd_lat;
    int n_errors = 0;
    int comparisons = 0;
    cbo_bridge i_dut (.*);
    cbo_target_model i_tgt (.*);
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, rd);
    endtask
    // Write data is always the inverse of the last stored word
    task automatic req(input logic w, input logic [2:0] p, input logic m);
        @(posedge pclk);
        {core_req_valid, core_req_write, core_req_policy, core_req_mcu} <= {1'b1, w, p, m};
        core_req_wdata <= ~cur;
        do @(negedge pclk); while (core_req_ready !== 1'b1);
        @(posedge pclk);
        core_req_valid <= 1'b0;
    endtask
    task automatic rsp(input logic e, input logic [31:0] d, input logic c);
        do @(negedge pclk); while (core_rsp_valid !== 1'b1);
        chk("core_rsp_error", {31'h0, e}, {31'h0, core_rsp_error});
        if (c)
            chk("core_rsp_rdata", d, core_rsp_rdata);
    endtask
    task automatic t_regs();
        for (int a = 0; a < 16; a += 4)
            rchk(a[11:0], 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        chk("prdata", 32'h0, rd);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        rchk(12'h004, 32'h0);
    endtask
    task automatic t_abort(input logic [31:0] m);
        apb(1'b1, 12'h008, m);
        rchk(12'h008, m & 32'h2000_0000);
        abort_on <= 1'b1;
        req(1'b1, 3'h1, 1'b0);
        do @(negedge pclk); while (ib_cpl_valid !== 1'b1);
        @(negedge pclk);
        chk("core_rsp_valid", 32'h0, {31'h0, core_rsp_valid});
        req(1'b0, 3'h1, 1'b0);
        rsp(1'b1, 32'h0, 1'b0);
        abort_on <= 1'b0;
        chk("irq", {31'h0, m[29]}, {31'h0, irq});
        rchk(12'h004, m & 32'h2000_0000);
        rchk(12'h004, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
    endtask
    // Slow reads, prompt writes: the write lands before the read returns
    task automatic t_pass();
        logic [2:0] pol [4] = '{3'h1, 3'h5, 3'h2, 3'h3};
        rd_lat <= 4'h8;
        foreach (pol[i])
        begin
            req(1'b0, pol[i], 1'b0);
            req(1'b1, pol[i], 1'b0);
            rsp(1'b0, ~cur, 1'b1);
            cur = ~cur;
        end
    endtask
    task automatic t_order();
        logic [2:0] pol [3] = '{3'h0, 3'h1, 3'h3};
        rd_lat <= 4'h2;
        foreach (pol[i])
        begin
            if (i == 2)
                apb(1'b1, 12'h000, 32'h1);
            req(1'b0, pol[i], i == 1);
            @(negedge pclk);
            chk("ib_cmd_fill", {31'h0, i == 2}, {31'h0, ib_cmd_fill});
            fork
                rsp(1'b0, cur, 1'b1);
                req(1'b1, pol[i], i == 1);
            join
            if (i < 2)
                rsp(1'b0, 32'h0, 1'b0);
            cur = ~cur;
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #200us;
        n_errors++;
        $display("MISMATCH watchdog expected done seen hang");
        conclude();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, abort_on, rd_lat} <= '0;
        {core_req_valid, core_req_write, core_req_wdata, core_req_policy, core_req_mcu} <= '0;
        core_req_addr <= 32'h0000_0040;
        cur = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_abort(32'hFFFF_FFFF);
        t_abort(32'h0);
        t_pass();
        t_order();
        conclude();
    end
endmodule
